// ---- fsph_pkg.sv ----
// Shared constants for the flash status, protection and pause block
package fsph_pkg;

	// ****************************************************************
	// Status word layout
	// ****************************************************************
	localparam int          SW_W        = 24;
	localparam int          BIT_BUSY    = 0;
	localparam int          BIT_WEL     = 1;
	localparam int          BG_LSB      = 2;
	localparam int          SRG_LO      = 7;
	localparam int          SRG_HI      = 8;
	localparam int          BIT_QE      = 9;
	localparam int          BIT_PPAUSE  = 10;
	localparam int          OTP_LSB     = 11;
	localparam int          OTP_MSB     = 13;
	localparam int          BIT_INV     = 14;
	localparam int          BIT_EPAUSE  = 15;
	localparam int          BIT_HPF     = 20;
	localparam int          DRV_LSB     = 21;
	localparam int          DRV_MSB     = 22;
	// Bits that a status write may touch; the others are reserved or held elsewhere
	localparam logic [23:0] WR_MASK     = 24'h607bfc;
	localparam logic [23:0] OTP_MASK    = 24'h003800;
	localparam logic [23:0] RSV_MASK    = 24'h8f0000;
	localparam logic [23:0] LANE_LO     = 24'h0000ff;
	localparam logic [23:0] LANE_LO_MID = 24'h00ffff;
	localparam logic [23:0] LANE_MID    = 24'h00ff00;
	localparam logic [23:0] LANE_HI     = 24'hff0000;
	localparam logic [1:0]  DRV_DEFAULT = 2'h1;

	// ****************************************************************
	// Status guard modes
	// ****************************************************************
	localparam logic [1:0]  SRG_SOFT    = 2'h0;
	localparam logic [1:0]  SRG_HW      = 2'h1;
	localparam logic [1:0]  SRG_LOCKED  = 2'h2;
	localparam logic [1:0]  SRG_OTP     = 2'h3;

	// ****************************************************************
	// Instruction codes
	// ****************************************************************
	localparam logic [7:0]  OP_WREN     = 8'h06;
	localparam logic [7:0]  OP_WRDI     = 8'h04;
	localparam logic [7:0]  OP_RDSR_LO  = 8'h05;
	localparam logic [7:0]  OP_RDSR_MID = 8'h35;
	localparam logic [7:0]  OP_RDSR_HI  = 8'h15;
	localparam logic [7:0]  OP_WRSR     = 8'h01;
	localparam logic [7:0]  OP_WRSR_MID = 8'h31;
	localparam logic [7:0]  OP_WRSR_HI  = 8'h11;
	localparam logic [7:0]  OP_PROG     = 8'h02;
	localparam logic [7:0]  OP_SECT     = 8'h20;
	localparam logic [7:0]  OP_BLK32    = 8'h52;
	localparam logic [7:0]  OP_BLK64    = 8'hd8;
	localparam logic [7:0]  OP_CHIP_A   = 8'hc7;
	localparam logic [7:0]  OP_CHIP_B   = 8'h60;
	localparam logic [7:0]  OP_SUSPEND  = 8'h75;
	localparam logic [7:0]  OP_RESUME   = 8'h7a;
	localparam logic [7:0]  OP_DPD      = 8'hb9;
	localparam logic [7:0]  OP_RELEASE  = 8'hab;
	localparam logic [7:0]  OP_RST_EN   = 8'h66;
	localparam logic [7:0]  OP_RST      = 8'h99;

	// ****************************************************************
	// Frame lengths in bits, clock rate, array job kinds
	// ****************************************************************
	localparam logic [5:0]  CNT_OP      = 6'h08;
	localparam logic [5:0]  CNT_ONE     = 6'h10;
	localparam logic [5:0]  CNT_TWO     = 6'h18;
	localparam logic [5:0]  CNT_ADDR    = 6'h20;
	localparam logic [5:0]  CNT_PROG    = 6'h28;
	localparam logic [5:0]  CNT_MAX     = 6'h3f;
	localparam int          CLK_MHZ     = 10;

	typedef enum logic [1:0] {
		JOB_NONE,
		JOB_PROG,
		JOB_ERASE,
		JOB_CHIP
	} fsph_job_t;

endpackage : fsph_pkg

// ---- fsph_sync.sv ----
// Three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/100ps

module fsph_sync #(
	parameter int             W    = 1,
	parameter logic [W-1:0]   INIT = '0
) (
	// Clock and reset of the receiving domain
	input  wire logic         clk_in,
	input  wire logic         reset_in,
	// Asynchronous levels and their filtered copy
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);

	logic [W-1:0] stage1;
	logic [W-1:0] stage2;
	logic [W-1:0] stage3;

	generate
		if (W < 1) begin : g_bad_width
			$error("fsph_sync width must be at least one");
		end
	endgenerate

	// Shift chain; stage1 is read by stage2 only
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			stage1 <= INIT;
			stage2 <= INIT;
			stage3 <= INIT;
		end else begin
			stage1 <= d_in;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// Per bit: take the new level only when two stages agree
	generate
		for (genvar i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge clk_in) begin
				if (reset_in) begin
					q_out[i] <= INIT[i];
				end else if (stage2[i] == stage3[i]) begin
					q_out[i] <= stage3[i];
				end
			end
		end
	endgenerate

endmodule : fsph_sync

// ---- fsph_core.sv ----
// Status word, write protection, suspend and bus pause of a serial flash
`timescale 1ns/100ps

module fsph_core #(
	parameter int SRW_TIME_US   = 100,
	parameter int PROG_TIME_US  = 100,
	parameter int ERASE_TIME_US = 100,
	parameter int CHIP_TIME_US  = 100
) (
	// System clock and power-on reset
	input  wire logic        clk_in,
	input  wire logic        reset_in,
	// Serial link, clocked by the host
	input  wire logic        sclk_in,
	input  wire logic        cs_n_in,
	input  wire logic        si_in,
	output logic             so_out,
	output logic             so_oe_out,
	input  wire logic        quad_line_2_in,
	input  wire logic        quad_line_3_in,
	// Non-volatile cells and array engine
	input  wire logic [23:0] nv_image_in,
	input  wire logic        guard_hit_in,
	input  wire logic        hp_mode_in,
	output logic             array_start_out,
	output logic [1:0]       array_kind_out,
	output logic [23:0]      array_addr_out,
	// Status view
	output logic [23:0]      status_word_out,
	output logic [1:0]       output_strength_out,
	output logic             deep_down_out
);

	localparam logic [31:0] SRW_CYC   = 32'(SRW_TIME_US * fsph_pkg::CLK_MHZ);
	localparam logic [31:0] PROG_CYC  = 32'(PROG_TIME_US * fsph_pkg::CLK_MHZ);
	localparam logic [31:0] ERASE_CYC = 32'(ERASE_TIME_US * fsph_pkg::CLK_MHZ);
	localparam logic [31:0] CHIP_CYC  = 32'(CHIP_TIME_US * fsph_pkg::CLK_MHZ);

	generate
		if (SRW_TIME_US < 1 || PROG_TIME_US < 1 || ERASE_TIME_US < 1 ||
			CHIP_TIME_US < 1) begin : g_bad_time
			$error("fsph_core busy times must be at least 1 us");
		end
	endgenerate

	typedef enum logic {ST_IDLE, ST_CHECK} fsph_state_t;

	// ****************************************************************
	// Link domain (sclk_in); frame flag and read-out state reset by deselect
	// ****************************************************************
	logic        lk_fresh;
	logic [5:0]  lk_count;
	logic [31:0] lk_shift;
	logic [7:0]  lk_op;
	logic [23:0] lk_addr;
	logic        lk_rd_on;
	logic [7:0]  lk_rd_byte;
	logic [2:0]  lk_idx;
	logic        lk_so;
	logic        lk_oe;
	logic [24:0] lk_view;
	logic        lk_go;
	logic [7:0]  lk_cand;
	logic        lk_is_rd;
	logic [7:0]  lk_pick;

	// Status copy for read-out; slow-changing, filtered per bit
	fsph_sync #(.W(25), .INIT(25'h0)) u_lk_sync (
		.clk_in   (sclk_in),
		.reset_in (1'b0),
		.d_in     ({deep_down_out, status_word_out}),
		.q_out    (lk_view)
	);

	// Pause pin counts only when quad mode leaves it a control input
	always_comb begin
		lk_go    = lk_view[fsph_pkg::BIT_QE] | quad_line_3_in;
		lk_cand  = (lk_count == fsph_pkg::CNT_OP - 6'h1) ?
			{lk_shift[6:0], si_in} : lk_op;
		lk_is_rd = (lk_cand == fsph_pkg::OP_RDSR_LO) ||
			(lk_cand == fsph_pkg::OP_RDSR_MID) ||
			(lk_cand == fsph_pkg::OP_RDSR_HI);
		unique case (lk_cand)
			fsph_pkg::OP_RDSR_MID: lk_pick = lk_view[15:8];
			fsph_pkg::OP_RDSR_HI:  lk_pick = lk_view[23:16];
			default:               lk_pick = lk_view[7:0];
		endcase
	end

	// First edge of a frame restarts the bit count
	always_ff @(posedge sclk_in or posedge cs_n_in) begin
		if (cs_n_in) begin
			lk_fresh <= 1'b1;
		end else if (lk_go) begin
			lk_fresh <= 1'b0;
		end
	end

	// Bits enter on rising edges; paused edges are ignored
	always_ff @(posedge sclk_in) begin
		if (lk_go) begin
			lk_shift <= {lk_shift[30:0], si_in};
			if (lk_fresh) begin
				lk_count <= 6'h1;
			end else if (lk_count != fsph_pkg::CNT_MAX) begin
				lk_count <= lk_count + 6'h1;
			end
			if (!lk_fresh && lk_count == fsph_pkg::CNT_OP - 6'h1) begin
				lk_op <= {lk_shift[6:0], si_in};
			end
			if (!lk_fresh && lk_count == fsph_pkg::CNT_ADDR - 6'h1) begin
				lk_addr <= {lk_shift[22:0], si_in};
			end
		end
	end

	// Status read: reload a byte at each byte boundary, repeating
	always_ff @(posedge sclk_in or posedge cs_n_in) begin
		if (cs_n_in) begin
			lk_rd_on   <= 1'b0;
			lk_rd_byte <= 8'h0;
		end else if (lk_go && !lk_fresh && lk_count[2:0] == 3'h7 &&
			lk_is_rd && !lk_view[24]) begin
			lk_rd_on   <= 1'b1;
			lk_rd_byte <= lk_pick;
		end
	end

	// Data leaves on falling edges, most significant bit first
	always_ff @(negedge sclk_in or posedge cs_n_in) begin
		if (cs_n_in) begin
			lk_idx <= 3'h7;
			lk_so  <= 1'b0;
			lk_oe  <= 1'b0;
		end else if (lk_go && lk_rd_on) begin
			lk_so  <= lk_rd_byte[lk_idx];
			lk_idx <= lk_idx - 3'h1;
			lk_oe  <= 1'b1;
		end
	end

	// Pause must float the pin with no clock edge, so the enable is gated
	// by the live pause level rather than taken only from the flop
	assign so_out    = lk_so;
	assign so_oe_out = lk_oe & lk_go;

	// ****************************************************************
	// System domain: pins and frame end
	// ****************************************************************
	logic [2:0]  pin_s;
	logic        cs_prev;
	logic        frame_end;
	logic        abandon;
	logic        wp_low;

	fsph_sync #(.W(3), .INIT(3'h7)) u_pin_sync (
		.clk_in   (clk_in),
		.reset_in (reset_in),
		.d_in     ({cs_n_in, quad_line_2_in, quad_line_3_in}),
		.q_out    (pin_s)
	);

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			cs_prev <= 1'b1;
		end else begin
			cs_prev <= pin_s[2];
		end
	end

	// Link registers are stable while deselected, so they are read here
	// only after the filtered deselect edge
	logic [23:0] nv_q;
	assign frame_end = pin_s[2] && !cs_prev;
	assign abandon   = !pin_s[0] && !nv_q[fsph_pkg::BIT_QE];
	assign wp_low    = !pin_s[1] && !nv_q[fsph_pkg::BIT_QE];

	// ****************************************************************
	// Instruction execution
	// ****************************************************************
	fsph_state_t st;
	logic [7:0]  ex_op;
	logic [5:0]  ex_count;
	logic [15:0] ex_data;
	logic        write_enable_latch;
	logic        dpd;
	logic        rst_armed;
	logic        epause;
	logic        ppause;
	logic        high_perf_flag;
	fsph_pkg::fsph_job_t job;
	logic [31:0] timer;
	logic        suspended;
	logic        busy;
	logic        done;
	logic        sr_lock;
	logic        chip_ok;
	logic        allowed;
	logic        do_wrsr;
	logic        do_job;
	fsph_pkg::fsph_job_t next_job;
	logic [23:0] wr_lane;
	logic [23:0] wr_data;
	logic [1:0]  srg;

	// Capture a finished frame, then judge it one cycle later
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			st       <= ST_IDLE;
			ex_op    <= 8'h0;
			ex_count <= 6'h0;
			ex_data  <= 16'h0;
		end else begin
			unique case (st)
				ST_IDLE: begin
					if (frame_end && !abandon) begin
						st       <= ST_CHECK;
						ex_op    <= lk_op;
						ex_count <= lk_count;
						ex_data  <= lk_shift[15:0];
					end
				end
				ST_CHECK: begin
					st <= ST_IDLE;
				end
			endcase
		end
	end

	assign srg       = {nv_q[fsph_pkg::SRG_HI], nv_q[fsph_pkg::SRG_LO]};
	assign suspended = epause | ppause;
	assign busy      = (job != fsph_pkg::JOB_NONE) && !suspended;
	assign done      = busy && timer == 32'h1;

	// Decode and protection checks for the judged frame
	always_comb begin
		sr_lock = (srg == fsph_pkg::SRG_HW && wp_low) ||
			srg == fsph_pkg::SRG_LOCKED ||
			srg == fsph_pkg::SRG_OTP;
		chip_ok = (nv_q[4:2] == 3'h0 && !nv_q[fsph_pkg::BIT_INV]) ||
			(nv_q[4:2] == 3'h7 && nv_q[fsph_pkg::BIT_INV]);
		if (dpd) begin
			allowed = ex_op == fsph_pkg::OP_RELEASE;
		end else if (busy) begin
			allowed = ex_op == fsph_pkg::OP_SUSPEND;
		end else begin
			allowed = 1'b1;
		end
		allowed = allowed && st == ST_CHECK;
		wr_lane = 24'h0;
		wr_data = 24'h0;
		unique case (ex_op)
			fsph_pkg::OP_WRSR: begin
				if (ex_count == fsph_pkg::CNT_TWO) begin
					wr_lane = fsph_pkg::LANE_LO_MID;
					wr_data = {8'h0, ex_data[7:0], ex_data[15:8]};
				end else if (ex_count == fsph_pkg::CNT_ONE) begin
					wr_lane = fsph_pkg::LANE_LO;
					wr_data = {16'h0, ex_data[7:0]};
				end
			end
			fsph_pkg::OP_WRSR_MID: begin
				if (ex_count == fsph_pkg::CNT_ONE) begin
					wr_lane = fsph_pkg::LANE_MID;
					wr_data = {8'h0, ex_data[7:0], 8'h0};
				end
			end
			fsph_pkg::OP_WRSR_HI: begin
				if (ex_count == fsph_pkg::CNT_ONE) begin
					wr_lane = fsph_pkg::LANE_HI;
					wr_data = {ex_data[7:0], 16'h0};
				end
			end
			default: begin
				wr_lane = 24'h0;
				wr_data = 24'h0;
			end
		endcase
		do_wrsr = allowed && write_enable_latch && !sr_lock && wr_lane != 24'h0;
		next_job = fsph_pkg::JOB_NONE;
		unique case (ex_op)
			fsph_pkg::OP_PROG: begin
				if (ex_count >= fsph_pkg::CNT_PROG && ex_count[2:0] == 3'h0) begin
					next_job = fsph_pkg::JOB_PROG;
				end
			end
			fsph_pkg::OP_SECT, fsph_pkg::OP_BLK32, fsph_pkg::OP_BLK64: begin
				if (ex_count == fsph_pkg::CNT_ADDR) begin
					next_job = fsph_pkg::JOB_ERASE;
				end
			end
			fsph_pkg::OP_CHIP_A, fsph_pkg::OP_CHIP_B: begin
				if (ex_count == fsph_pkg::CNT_OP && chip_ok) begin
					next_job = fsph_pkg::JOB_CHIP;
				end
			end
			default: next_job = fsph_pkg::JOB_NONE;
		endcase
		do_job = allowed && write_enable_latch && next_job != fsph_pkg::JOB_NONE &&
			(next_job == fsph_pkg::JOB_CHIP || !guard_hit_in);
	end

	// Array job launch towards the array engine
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			array_start_out <= 1'b0;
			array_kind_out  <= fsph_pkg::JOB_NONE;
			array_addr_out  <= 24'h0;
		end else begin
			array_start_out <= do_job;
			if (do_job) begin
				array_kind_out <= next_job;
			end
			if (frame_end && st == ST_IDLE) begin
				array_addr_out <= lk_addr;
			end
		end
	end

	// Busy timer; a suspended job freezes where it stands
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			job   <= fsph_pkg::JOB_NONE;
			timer <= 32'h0;
		end else if (allowed && rst_armed && ex_op == fsph_pkg::OP_RST) begin
			job   <= fsph_pkg::JOB_NONE;
			timer <= 32'h0;
		end else if (do_wrsr) begin
			job   <= fsph_pkg::JOB_PROG;
			timer <= SRW_CYC;
		end else if (do_job) begin
			job   <= next_job;
			timer <= (next_job == fsph_pkg::JOB_PROG) ? PROG_CYC :
				(next_job == fsph_pkg::JOB_ERASE) ? ERASE_CYC : CHIP_CYC;
		end else if (done) begin
			job   <= fsph_pkg::JOB_NONE;
			timer <= 32'h0;
		end else if (busy) begin
			timer <= timer - 32'h1;
		end
	end

	// Write-enable latch; enable wins over a clear in the same cycle
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			write_enable_latch <= 1'b0;
		end else if (allowed && ex_op == fsph_pkg::OP_WREN &&
			ex_count == fsph_pkg::CNT_OP) begin
			write_enable_latch <= 1'b1;
		end else if (done || (allowed && (ex_op == fsph_pkg::OP_WRDI ||
			(rst_armed && ex_op == fsph_pkg::OP_RST)))) begin
			write_enable_latch <= 1'b0;
		end
	end

	// Suspend flags: set by suspend, cleared by resume or power cycle
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			epause <= 1'b0;
			ppause <= 1'b0;
		end else if (st == ST_CHECK && !dpd &&
			ex_op == fsph_pkg::OP_RESUME) begin
			epause <= 1'b0;
			ppause <= 1'b0;
		end else if (allowed && ex_op == fsph_pkg::OP_SUSPEND && busy &&
			timer != SRW_CYC) begin
			epause <= job != fsph_pkg::JOB_PROG;
			ppause <= job == fsph_pkg::JOB_PROG;
		end
	end

	// Deep power-down, two-step software reset, performance flag
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			dpd       <= 1'b0;
			rst_armed <= 1'b0;
			high_perf_flag       <= 1'b0;
		end else begin
			high_perf_flag <= hp_mode_in;
			if (allowed && ex_op == fsph_pkg::OP_DPD) begin
				dpd <= 1'b1;
			end else if (allowed && ex_op == fsph_pkg::OP_RELEASE) begin
				dpd <= 1'b0;
			end
			if (allowed) begin
				rst_armed <= ex_op == fsph_pkg::OP_RST_EN;
			end
		end
	end

	// Non-volatile bits: loaded from the cells at power-on, where a
	// power-cycle lock falls back to software mode; OTP bits only set
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			nv_q <= nv_image_in & fsph_pkg::WR_MASK;
			if ({nv_image_in[fsph_pkg::SRG_HI], nv_image_in[fsph_pkg::SRG_LO]}
				== fsph_pkg::SRG_LOCKED) begin
				nv_q[fsph_pkg::SRG_HI] <= 1'b0;
				nv_q[fsph_pkg::SRG_LO] <= 1'b0;
			end
		end else if (do_wrsr) begin
			nv_q <= (nv_q & ~(wr_lane & fsph_pkg::WR_MASK)) |
				(wr_data & wr_lane & fsph_pkg::WR_MASK) |
				(nv_q & fsph_pkg::OTP_MASK);
		end
	end

	// Status view: reserved bits stay zero since nv_q holds none
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			status_word_out     <= 24'h0;
			output_strength_out <= fsph_pkg::DRV_DEFAULT;
			deep_down_out       <= 1'b0;
		end else begin
			status_word_out <= nv_q;
			status_word_out[fsph_pkg::BIT_BUSY]   <= busy;
			status_word_out[fsph_pkg::BIT_WEL]    <= write_enable_latch;
			status_word_out[fsph_pkg::BIT_PPAUSE] <= ppause;
			status_word_out[fsph_pkg::BIT_EPAUSE] <= epause;
			status_word_out[fsph_pkg::BIT_HPF]    <= high_perf_flag;
			output_strength_out <= nv_q[fsph_pkg::DRV_MSB:fsph_pkg::DRV_LSB];
			deep_down_out       <= dpd;
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	a_no_latch_reject: assert property (@(posedge clk_in) disable iff (reset_in)
		(st == ST_CHECK && !write_enable_latch) |=> !array_start_out && $stable(nv_q))
		else $error("write accepted with latch clear");
	a_busy_after_start: assert property (@(posedge clk_in) disable iff (reset_in)
		array_start_out |=> status_word_out[0] || suspended)
		else $error("busy flag missing after job start");
	a_chip_guard: assert property (@(posedge clk_in) disable iff (reset_in)
		(array_start_out && array_kind_out == fsph_pkg::JOB_CHIP)
		|-> $past(chip_ok))
		else $error("chip erase started while guarded");
	a_otp_sticky: assert property (@(posedge clk_in) disable iff (reset_in)
		(nv_q & $past(nv_q) & fsph_pkg::OTP_MASK)
		== ($past(nv_q) & fsph_pkg::OTP_MASK))
		else $error("lock bit cleared");
	a_locked_stable: assert property (@(posedge clk_in) disable iff (reset_in)
		(srg == fsph_pkg::SRG_LOCKED || srg == fsph_pkg::SRG_OTP)
		|=> $stable(nv_q))
		else $error("locked status word changed");
	a_dpd_ignores: assert property (@(posedge clk_in) disable iff (reset_in)
		(dpd && st == ST_CHECK && ex_op != fsph_pkg::OP_RELEASE)
		|=> dpd && !array_start_out && $stable(write_enable_latch))
		else $error("instruction obeyed in deep power-down");
	a_pause_not_busy: assert property (@(posedge clk_in) disable iff (reset_in)
		suspended |=> !status_word_out[0])
		else $error("busy shown while suspended");
	a_done_clears_wel: assert property (@(posedge clk_in) disable iff (reset_in)
		done |=> !write_enable_latch ##1 !status_word_out[1])
		else $error("latch not cleared at job end");
	a_reserved_zero: assert property (@(posedge clk_in) disable iff (reset_in)
		(status_word_out & fsph_pkg::RSV_MASK) == 24'h0)
		else $error("reserved status bit set");
	a_hw_lock_pin: assert property (@(posedge clk_in) disable iff (reset_in)
		(st == ST_CHECK && srg == fsph_pkg::SRG_HW && wp_low)
		|=> $stable(nv_q))
		else $error("status written with protect pin low");

endmodule : fsph_core

// ---- fsph_host.sv ----
// Host model of the serial link: frames with a 15 ns serial clock
`timescale 1ns/100ps

module fsph_host (
	// Link toward the device
	output logic      sclk_out,
	output logic      cs_n_out,
	output logic      si_out,
	output logic      pause_n_out,
	input  wire logic so_in,
	input  wire logic so_oe_in
);
	// Idle: deselected, clock stands still low (mode 0)
	initial begin
		sclk_out    = 1'b0;
		cs_n_out    = 1'b1;
		si_out      = 1'b0;
		pause_n_out = 1'b1;
	end

	// Shift n bits MSB first; rd gathers so on rising edges; p > 0 puts
	// a pause after bit p, with clock pulses the device must ignore
	task automatic send(input logic [39:0] v, input int n, input int p,
		output logic [7:0] rd, output logic oe_p);
		cs_n_out = 1'b0;
		#20;
		for (int i = n - 1; i >= 0; i--) begin
			si_out = v[i];
			#7.5 sclk_out = 1'b1;
			rd = {rd[6:0], so_in};
			#7.5 sclk_out = 1'b0;
			if (n - i == p) begin
				#5 pause_n_out = 1'b0; // Select held, clock low
				#5 oe_p = so_oe_in;
				repeat (2) begin
					si_out = ~si_out;
					#7.5 sclk_out = 1'b1;
					#7.5 sclk_out = 1'b0;
				end
				#200 pause_n_out = 1'b1; // Clock low at exit
				#5;
			end
		end
		#20 cs_n_out = 1'b1;
		si_out = ~si_out; // A released line keeps no stale value
	endtask : send
endmodule : fsph_host

// ---- flash_status_protect_hold_bench.sv ----
// Self-checking bench for the flash status, protection and pause block
`timescale 1ns/100ps

module flash_status_protect_hold_bench;
	logic        clk_in;
	logic        reset_in;
	logic        sclk, cs_n, si, pause_n, so, so_oe, so_w;
	logic        wp_n, hp_mode, look, oe_p, a_start, deep, guard_hit;
	logic [1:0]  kind, strength;
	logic [23:0] addr, status, nv_image;
	logic [23:0] exp_q[$];
	logic [7:0]  d, rd;
	int          n_mismatch = 0;
	int          cmp_count = 0;
	int          n_start = 0;
	int          cycles = 0;
	int          seed;

	// Undriven output line reads the inverse of the host's data
	assign so_w = so_oe ? so : ~si;

	fsph_core #(.SRW_TIME_US(2), .PROG_TIME_US(2), .ERASE_TIME_US(2),
		.CHIP_TIME_US(2)) dut (
		.clk_in(clk_in), .reset_in(reset_in), .sclk_in(sclk),
		.cs_n_in(cs_n), .si_in(si), .so_out(so), .so_oe_out(so_oe),
		.quad_line_2_in(wp_n), .quad_line_3_in(pause_n),
		.nv_image_in(nv_image), .guard_hit_in(guard_hit),
		.hp_mode_in(hp_mode), .array_start_out(a_start),
		.array_kind_out(kind), .array_addr_out(addr),
		.status_word_out(status), .output_strength_out(strength),
		.deep_down_out(deep));

	fsph_host host (.sclk_out(sclk), .cs_n_out(cs_n), .si_out(si),
		.pause_n_out(pause_n), .so_in(so_w), .so_oe_in(so_oe));

	// ****************************************************************
	// Clock, checks and verdict
	// ****************************************************************
	initial begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end

	task automatic check(input logic [23:0] seen, input logic [23:0] want);
		cmp_count++;
		if (seen !== want) begin
			n_mismatch++;
			$display("Error at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask : check

	task automatic tally_and_finish;
		$display("Mismatches %0d, comparisons %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : tally_and_finish

	// Expectation is queued, then looked at once the write has settled
	task automatic note(input logic [23:0] want);
		exp_q.push_back(want);
		repeat (40) @(negedge clk_in);
		look = 1'b1;
		@(negedge clk_in);
		look = 1'b0;
	endtask : note

	// Frames keep the deselect gap the link needs between them
	task automatic op(input logic [15:0] v, input int n);
		repeat (8) @(negedge clk_in);
		host.send({24'h000000, v}, n, 0, rd, oe_p);
	endtask : op

	// Watcher takes the oldest note whenever a result is due
	always @(posedge clk_in) begin
		if (look)
			check(status, exp_q.pop_front());
		if (a_start)
			n_start++;
	end

	// Hang guard, far above the expected run length
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end

	// Main sequence
	initial begin
		seed = 32'ha5fe;
		// Cells as shipped: only the drive field is off zero
		nv_image = 24'h200000;
		guard_hit = 1'b0;
		reset_in = 1'b1;
		wp_n = 1'b1;
		hp_mode = 1'b0;
		look = 1'b0;
		repeat (8) @(negedge clk_in);
		reset_in = 1'b0;
		repeat (6) @(negedge clk_in);
		check({22'h000000, strength}, 24'h000001);
		note(24'h200000);
		d = 8'($random(seed)) & 8'h7c;
		op(16'h0006, 8);
		note(24'h200002);
		op({8'h01, d}, 16);
		note({8'h20, 8'h00, d});
		repeat (8) @(negedge clk_in);
		host.send({24'h000000, 8'h05, 8'h00}, 16, 12, rd, oe_p);
		check({16'h0000, rd}, {16'h0000, d});
		check({23'h000000, oe_p}, 24'h000000);
		op({8'h01, ~d & 8'h7c}, 16);
		note({8'h20, 8'h00, d});
		op(16'h0006, 8);
		op({8'h01, d | 8'h80}, 16);
		note({8'h20, 8'h00, d | 8'h80});
		wp_n = 1'b0;
		hp_mode = 1'b1;
		op(16'h0006, 8);
		op(16'h0100, 16);
		note({8'h30, 8'h00, d | 8'h82});
		// Sector erase into a guarded region is refused, latch kept
		guard_hit = 1'b1;
		repeat (8) @(negedge clk_in);
		host.send({16'h0020, 24'h001000}, 32, 0, rd, oe_p);
		note({8'h30, 8'h00, d | 8'h82});
		// Same erase outside the guard runs and clears the latch
		guard_hit = 1'b0;
		repeat (8) @(negedge clk_in);
		host.send({16'h0020, 24'h001000}, 32, 0, rd, oe_p);
		note({8'h30, 8'h00, d | 8'h80});
		check({22'h000000, kind}, 24'h000002);
		check(addr, 24'h001000);
		check(24'(n_start), 24'h000001);
		// Deep power-down drops a write enable until released
		op(16'h00b9, 8);
		op(16'h0006, 8);
		note({8'h30, 8'h00, d | 8'h80});
		check({23'h000000, deep}, 24'h000001);
		op(16'h00ab, 8);
		op(16'h0006, 8);
		note({8'h30, 8'h00, d | 8'h82});
		check({23'h000000, deep}, 24'h000000);
		tally_and_finish();
	end
endmodule : flash_status_protect_hold_bench
